/* File: rrte_pkg.sv */
// constants, opcodes and types for the register and ram transfer executor
package rrte_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int INSTR_W = 10;
    localparam int DATA_W  = 4;
    localparam int BANK_W  = 2;
    localparam int TBL_W   = 3;
    localparam int STK_W   = 3;
    localparam int EXT_W   = 8;
    localparam int RAM_AW  = BANK_W + 2 * DATA_W;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] NIB_RST   = 4'h0;
    localparam logic [BANK_W-1:0] BANK_RST  = 2'h0;
    localparam logic [TBL_W-1:0]  TBL_RST   = 3'h0;
    localparam logic [EXT_W-1:0]  EXT_RST   = 8'h00;

    // ------------------------------------------------------------------
    // skip results of the digit pointer step
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] DIG_INC_SKIP = 4'h0;
    localparam logic [DATA_W-1:0] DIG_DEC_SKIP = 4'hF;

    // ------------------------------------------------------------------
    // full opcodes
    // ------------------------------------------------------------------
    localparam logic [INSTR_W-1:0] OPC_B2A  = 10'h01E;
    localparam logic [INSTR_W-1:0] OPC_A2B  = 10'h00E;
    localparam logic [INSTR_W-1:0] OPC_Y2A  = 10'h01F;
    localparam logic [INSTR_W-1:0] OPC_A2Y  = 10'h00C;
    localparam logic [INSTR_W-1:0] OPC_P2E  = 10'h01A;
    localparam logic [INSTR_W-1:0] OPC_E2P  = 10'h02A;
    localparam logic [INSTR_W-1:0] OPC_A2D  = 10'h029;
    localparam logic [INSTR_W-1:0] OPC_D2A  = 10'h051;
    localparam logic [INSTR_W-1:0] OPC_Z2A  = 10'h053;
    localparam logic [INSTR_W-1:0] OPC_X2A  = 10'h052;
    localparam logic [INSTR_W-1:0] OPC_SP2A = 10'h050;
    localparam logic [INSTR_W-1:0] OPC_INC  = 10'h013;
    localparam logic [INSTR_W-1:0] OPC_DEC  = 10'h017;

    // ------------------------------------------------------------------
    // opcode prefixes of instructions with an immediate field
    // ------------------------------------------------------------------
    localparam logic [1:0] PFX_LPT  = 2'h3;
    localparam logic [7:0] PFX_LB   = 8'h12;
    localparam logic [5:0] PFX_LDM  = 6'h2C;
    localparam logic [5:0] PFX_SWM  = 6'h2D;
    localparam logic [5:0] PFX_SWMI = 6'h2E;
    localparam logic [5:0] PFX_SWMD = 6'h2F;
    localparam logic [5:0] PFX_STM  = 6'h2B;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NONE, OP_B2A, OP_A2B, OP_Y2A, OP_A2Y, OP_P2E, OP_E2P, OP_A2D,
        OP_D2A, OP_Z2A, OP_X2A, OP_SP2A, OP_LPT, OP_LB, OP_INC, OP_DEC,
        OP_LDM, OP_SWM, OP_SWMD, OP_SWMI, OP_STM
    } rrte_op_t;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_SKIP = 2'b10
    } rrte_state_t;

endpackage : rrte_pkg

/* File: rrte_exec_if.sv */
// interface joining the executor core, its decoder and its ram
`timescale 1ns/1ns
interface rrte_exec_if;
    import rrte_pkg::*;

    logic [INSTR_W-1:0] instr;
    rrte_op_t           op;
    logic [DATA_W-1:0]  imm_hi;
    logic [DATA_W-1:0]  imm_lo;
    logic [RAM_AW-1:0]  ram_addr;
    logic [DATA_W-1:0]  ram_wdata;
    logic [DATA_W-1:0]  ram_rdata;
    logic               ram_we;

    modport core (output instr, ram_addr, ram_wdata, ram_we,
                  input  op, imm_hi, imm_lo, ram_rdata);
    modport dec  (input  instr, output op, imm_hi, imm_lo);
    modport mem  (input  ram_addr, ram_wdata, ram_we, output ram_rdata);

endinterface : rrte_exec_if

/* File: rrte_decode.sv */
// opcode decoder for the transfer and pointer instruction groups
`timescale 1ns/1ns
module rrte_decode (
    rrte_exec_if.dec dif
);
    import rrte_pkg::*;

    // ------------------------------------------------------------------
    // opcode to operation
    // ------------------------------------------------------------------
    function automatic rrte_op_t rrte_decode_op(input logic [INSTR_W-1:0] ins);
        rrte_op_t res;
        res = OP_NONE;
        case (ins)
            OPC_B2A:  res = OP_B2A;
            OPC_A2B:  res = OP_A2B;
            OPC_Y2A:  res = OP_Y2A;
            OPC_A2Y:  res = OP_A2Y;
            OPC_P2E:  res = OP_P2E;
            OPC_E2P:  res = OP_E2P;
            OPC_A2D:  res = OP_A2D;
            OPC_D2A:  res = OP_D2A;
            OPC_Z2A:  res = OP_Z2A;
            OPC_X2A:  res = OP_X2A;
            OPC_SP2A: res = OP_SP2A;
            OPC_INC:  res = OP_INC;
            OPC_DEC:  res = OP_DEC;
            default: begin
                if (ins[9:8] == PFX_LPT) begin
                    res = OP_LPT;
                end else if (ins[9:2] == PFX_LB) begin
                    res = OP_LB;
                end else begin
                    case (ins[9:4])
                        PFX_LDM:  res = OP_LDM;
                        PFX_SWM:  res = OP_SWM;
                        PFX_SWMI: res = OP_SWMI;
                        PFX_SWMD: res = OP_SWMD;
                        PFX_STM:  res = OP_STM;
                        default:  res = OP_NONE;
                    endcase
                end
            end
        endcase
        return res;
    endfunction : rrte_decode_op

    assign dif.op     = rrte_decode_op(dif.instr);
    assign dif.imm_hi = dif.instr[7:4];
    assign dif.imm_lo = dif.instr[3:0];

endmodule : rrte_decode

/* File: rrte_ram.sv */
// nibble-wide data ram addressed by bank, file and digit pointers
`timescale 1ns/1ns
module rrte_ram #(
    parameter int DEPTH = 1 << rrte_pkg::RAM_AW
) (
    input  wire logic CLK,
    rrte_exec_if.mem  mif
);
    import rrte_pkg::*;

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] mem_r [DEPTH];

    generate
        if (DEPTH < 1 || DEPTH > (1 << RAM_AW)) begin : g_bad_depth
            $error("ram depth must lie between 1 and the pointer range");
        end
    endgenerate

    // old contents read in the same cycle as the write, so a swap sees them
    assign mif.ram_rdata = (int'(mif.ram_addr) < DEPTH) ? mem_r[mif.ram_addr] : NIB_RST;

    always_ff @(posedge CLK) begin
        if (mif.ram_we && int'(mif.ram_addr) < DEPTH) begin
            mem_r[mif.ram_addr] <= mif.ram_wdata;
        end
    end

endmodule : rrte_ram

/* File: rrte_core.sv */
// execution core for register transfers and ram address/transfer instructions
//
// Operation
// - second register to accumulator copies all four bits, source kept.
// - accumulator to second register copies, accumulator kept.
// - digit pointer copied into the accumulator.
// - accumulator copied into the digit pointer.
// - extended register takes second register high, accumulator low, together.
// - extended high nibble to second register, low nibble to accumulator.
// - low three accumulator bits go into the table pointer.
// - table pointer goes into the low three accumulator bits.
// - bank pointer goes into the low two accumulator bits.
// - file pointer copied into the accumulator.
// - stack level into low three accumulator bits, stack level untouched.
// - pointer load puts first nibble in file, second in digit pointer.
// - back-to-back pointer loads: only the first runs, followers skipped.
// - bank load writes the two-bit immediate into the bank pointer.
// - digit increment wraps at sixteen, skips next when result is zero.
// - digit decrement wraps at sixteen, skips next when result is fifteen.
// - ram load to accumulator, then file pointer xor immediate.
// - ram and accumulator swap, then file pointer xor immediate.
// - swap with xor, then digit decrement skipping on fifteen.
// - swap with xor, then digit increment skipping on zero.
// - accumulator stored to ram, then file pointer xor immediate.
// - bank read clears the two upper accumulator bits.
`timescale 1ns/1ns
module rrte_core
    import rrte_pkg::*;
(
    // clock and reset
    input  wire logic                        CLK,
    input  wire logic                        ARST_N,
    // instruction stream, one per valid cycle
    input  wire logic                        INSTR_VALID,
    input  wire logic [rrte_pkg::INSTR_W-1:0] INSTR,
    // state kept by other parts of the cpu
    input  wire logic [rrte_pkg::STK_W-1:0]  STACK_LEVEL,
    input  wire logic                        CARRY_LOAD,
    input  wire logic                        CARRY_IN,
    // register view
    output logic      [rrte_pkg::DATA_W-1:0] ACC,
    output logic      [rrte_pkg::DATA_W-1:0] REG_B,
    output logic      [rrte_pkg::DATA_W-1:0] PTR_X,
    output logic      [rrte_pkg::DATA_W-1:0] PTR_Y,
    output logic      [rrte_pkg::BANK_W-1:0] PTR_Z,
    output logic      [rrte_pkg::TBL_W-1:0]  PTR_D,
    output logic      [rrte_pkg::EXT_W-1:0]  REG_E,
    output logic                             CARRY,
    // execution status
    output logic                             SKIP_PENDING,
    output logic                             INSTR_SKIPPED,
    output logic                             INSTR_UNKNOWN
);
    import rrte_pkg::*;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    rrte_exec_if xif ();

    rrte_state_t       state_r;
    rrte_state_t       state_nxt;
    logic [DATA_W-1:0] acc_r;
    logic [DATA_W-1:0] acc_nxt;
    logic [DATA_W-1:0] b_r;
    logic [DATA_W-1:0] b_nxt;
    logic [DATA_W-1:0] x_r;
    logic [DATA_W-1:0] x_nxt;
    logic [DATA_W-1:0] y_r;
    logic [DATA_W-1:0] y_nxt;
    logic [BANK_W-1:0] z_r;
    logic [BANK_W-1:0] z_nxt;
    logic [TBL_W-1:0]  d_r;
    logic [TBL_W-1:0]  d_nxt;
    logic [EXT_W-1:0]  e_r;
    logic [EXT_W-1:0]  e_nxt;
    logic              carry_flag_r;
    logic              lpt_prev_r;
    logic              skipped_r;
    logic              unknown_r;

    rrte_op_t          op;
    logic              skip_now;
    logic              do_exec;
    logic              skip_req;
    logic [DATA_W-1:0] y_inc;
    logic [DATA_W-1:0] y_dec;
    logic              is_swap;
    logic              is_xmod;

    // ------------------------------------------------------------------
    // decoder and ram
    // ------------------------------------------------------------------
    assign xif.instr = INSTR;
    assign op        = xif.op;

    rrte_decode u_decode (
        .dif (xif.dec)
    );

    rrte_ram u_ram (
        .CLK (CLK),
        .mif (xif.mem)
    );

    // ------------------------------------------------------------------
    // execute or skip
    // ------------------------------------------------------------------
    // a pointer load right after another pointer load is passed over
    assign skip_now = (state_r == ST_SKIP) || (op == OP_LPT && lpt_prev_r);
    assign do_exec  = INSTR_VALID && !skip_now;

    assign y_inc   = DATA_W'(y_r + 1'b1);
    assign y_dec   = DATA_W'(y_r - 1'b1);
    assign is_swap = (op == OP_SWM) || (op == OP_SWMD) || (op == OP_SWMI);
    assign is_xmod = is_swap || (op == OP_LDM) || (op == OP_STM);

    always_comb begin
        skip_req = 1'b0;
        case (op)
            OP_INC:  skip_req = (y_inc == DIG_INC_SKIP);
            OP_SWMI: skip_req = (y_inc == DIG_INC_SKIP);
            OP_DEC:  skip_req = (y_dec == DIG_DEC_SKIP);
            OP_SWMD: skip_req = (y_dec == DIG_DEC_SKIP);
            default: skip_req = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------
    // skip state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (do_exec && skip_req) begin
                    state_nxt = ST_SKIP;
                end
            end
            ST_SKIP: begin
                // the skipped instruction still uses its cycle
                if (INSTR_VALID) begin
                    state_nxt = ST_RUN;
                end
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // chain of pointer loads counts fetched ones, skipped or not
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            lpt_prev_r <= 1'b0;
        end else if (INSTR_VALID) begin
            lpt_prev_r <= (op == OP_LPT);
        end
    end

    // ------------------------------------------------------------------
    // accumulator
    // ------------------------------------------------------------------
    always_comb begin
        acc_nxt = acc_r;
        if (do_exec) begin
            case (op)
                OP_B2A:  acc_nxt = b_r;
                OP_Y2A:  acc_nxt = y_r;
                OP_E2P:  acc_nxt = e_r[DATA_W-1:0];
                OP_D2A:  acc_nxt = DATA_W'(d_r);
                OP_Z2A:  acc_nxt = DATA_W'(z_r);
                OP_X2A:  acc_nxt = x_r;
                OP_SP2A: acc_nxt = DATA_W'(STACK_LEVEL);
                OP_LDM:  acc_nxt = xif.ram_rdata;
                OP_SWM,
                OP_SWMD,
                OP_SWMI: acc_nxt = xif.ram_rdata;
                default: acc_nxt = acc_r;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            acc_r <= NIB_RST;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // ------------------------------------------------------------------
    // second working register
    // ------------------------------------------------------------------
    always_comb begin
        b_nxt = b_r;
        if (do_exec) begin
            case (op)
                OP_A2B:  b_nxt = acc_r;
                OP_E2P:  b_nxt = e_r[EXT_W-1:DATA_W];
                default: b_nxt = b_r;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            b_r <= NIB_RST;
        end else begin
            b_r <= b_nxt;
        end
    end

    // ------------------------------------------------------------------
    // extended register
    // ------------------------------------------------------------------
    assign e_nxt = (do_exec && op == OP_P2E) ? {b_r, acc_r} : e_r;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            e_r <= EXT_RST;
        end else begin
            e_r <= e_nxt;
        end
    end

    // ------------------------------------------------------------------
    // file pointer
    // ------------------------------------------------------------------
    always_comb begin
        x_nxt = x_r;
        if (do_exec) begin
            if (op == OP_LPT) begin
                x_nxt = xif.imm_hi;
            end else if (is_xmod) begin
                // ram is addressed with the old value in this same cycle
                x_nxt = x_r ^ xif.imm_lo;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            x_r <= NIB_RST;
        end else begin
            x_r <= x_nxt;
        end
    end

    // ------------------------------------------------------------------
    // digit pointer
    // ------------------------------------------------------------------
    always_comb begin
        y_nxt = y_r;
        if (do_exec) begin
            case (op)
                OP_A2Y:  y_nxt = acc_r;
                OP_LPT:  y_nxt = xif.imm_lo;
                OP_INC:  y_nxt = y_inc;
                OP_SWMI: y_nxt = y_inc;
                OP_DEC:  y_nxt = y_dec;
                OP_SWMD: y_nxt = y_dec;
                default: y_nxt = y_r;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            y_r <= NIB_RST;
        end else begin
            y_r <= y_nxt;
        end
    end

    // ------------------------------------------------------------------
    // bank and table pointers
    // ------------------------------------------------------------------
    assign z_nxt = (do_exec && op == OP_LB)  ? xif.imm_lo[BANK_W-1:0] : z_r;
    assign d_nxt = (do_exec && op == OP_A2D) ? acc_r[TBL_W-1:0]       : d_r;

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            z_r <= BANK_RST;
        end else begin
            z_r <= z_nxt;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            d_r <= TBL_RST;
        end else begin
            d_r <= d_nxt;
        end
    end

    // ------------------------------------------------------------------
    // ram access
    // ------------------------------------------------------------------
    assign xif.ram_addr  = {z_r, x_r, y_r};
    assign xif.ram_wdata = acc_r;
    assign xif.ram_we    = do_exec && (is_swap || op == OP_STM);

    // ------------------------------------------------------------------
    // carry flag, owned by other instruction groups
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            carry_flag_r <= 1'b0;
        end else if (CARRY_LOAD) begin
            carry_flag_r <= CARRY_IN;
        end
    end

    // ------------------------------------------------------------------
    // status pulses
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            skipped_r <= 1'b0;
            unknown_r <= 1'b0;
        end else begin
            skipped_r <= INSTR_VALID && skip_now;
            unknown_r <= do_exec && (op == OP_NONE);
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign ACC           = acc_r;
    assign REG_B         = b_r;
    assign PTR_X         = x_r;
    assign PTR_Y         = y_r;
    assign PTR_Z         = z_r;
    assign PTR_D         = d_r;
    assign REG_E         = e_r;
    assign CARRY         = carry_flag_r;
    assign SKIP_PENDING  = (state_r == ST_SKIP);
    assign INSTR_SKIPPED = skipped_r;
    assign INSTR_UNKNOWN = unknown_r;

endmodule : rrte_core

/* File: rrte_core_monitor.sv */
// assertion checker for the transfer executor core
`timescale 1ns/1ns
module rrte_core_monitor
    import rrte_pkg::*;
(
    // clock and reset
    input wire logic                         CLK,
    input wire logic                         ARST_N,
    // instruction side
    input wire logic                         INSTR_VALID,
    input wire logic [rrte_pkg::INSTR_W-1:0] INSTR,
    input wire logic                         CARRY_LOAD,
    // register view
    input wire logic [rrte_pkg::DATA_W-1:0]  ACC,
    input wire logic [rrte_pkg::DATA_W-1:0]  REG_B,
    input wire logic [rrte_pkg::DATA_W-1:0]  PTR_X,
    input wire logic [rrte_pkg::DATA_W-1:0]  PTR_Y,
    input wire logic [rrte_pkg::BANK_W-1:0]  PTR_Z,
    input wire logic [rrte_pkg::EXT_W-1:0]   REG_E,
    input wire logic                         CARRY,
    // status
    input wire logic                         SKIP_PENDING,
    input wire logic                         INSTR_SKIPPED,
    input wire logic                         INSTR_UNKNOWN
);
    // --------
    // helpers
    // --------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    wire logic run = INSTR_VALID && !SKIP_PENDING;
    wire logic lpt = INSTR_VALID && INSTR[9:8] == PFX_LPT;

    // --------
    // checks
    // --------
    a_b_to_acc: assert property (run && INSTR == OPC_B2A |=>
        ACC == $past(REG_B) && $stable(REG_B)) else $error("acc not copied from b");
    a_pair_to_ext: assert property (run && INSTR == OPC_P2E |=>
        REG_E == {$past(REG_B), $past(ACC)}) else $error("bad pair to ext");
    a_ext_to_pair: assert property (run && INSTR == OPC_E2P |=>
        {REG_B, ACC} == $past(REG_E)) else $error("bad ext to pair");
    a_bank_read: assert property (run && INSTR == OPC_Z2A |=>
        ACC == {2'h0, $past(PTR_Z)}) else $error("bad bank read");
    a_inc_skip: assert property (run && INSTR == OPC_INC |=>
        PTR_Y == $past(PTR_Y) + 4'h1 && SKIP_PENDING == (PTR_Y == 4'h0))
        else $error("bad digit increment");
    a_dec_skip: assert property (run && INSTR == OPC_DEC |=>
        PTR_Y == $past(PTR_Y) - 4'h1 && SKIP_PENDING == (PTR_Y == 4'hF))
        else $error("bad digit decrement");
    a_skip_quiet: assert property (INSTR_VALID && SKIP_PENDING |=>
        INSTR_SKIPPED && !SKIP_PENDING && $stable({ACC, REG_B, PTR_X, PTR_Y, PTR_Z, REG_E}))
        else $error("skipped instruction had effect");
    a_load_chain: assert property (lpt ##1 lpt |=>
        INSTR_SKIPPED && $stable({PTR_X, PTR_Y})) else $error("chained load ran");
    a_carry_kept: assert property (!CARRY_LOAD |=> $stable(CARRY))
        else $error("carry changed");

    c_skip: cover property (INSTR_VALID && SKIP_PENDING);
    c_chain: cover property (lpt ##1 lpt);
    c_unknown: cover property (INSTR_UNKNOWN);
endmodule : rrte_core_monitor

bind rrte_core rrte_core_monitor rrte_core_monitor_inst (
    .CLK, .ARST_N, .INSTR_VALID, .INSTR, .CARRY_LOAD, .ACC, .REG_B, .PTR_X,
    .PTR_Y, .PTR_Z, .REG_E, .CARRY, .SKIP_PENDING, .INSTR_SKIPPED, .INSTR_UNKNOWN
);

/* File: rrte_core_tb.sv */
// self-checking bench for the transfer executor core against a behavioural model
`timescale 1ns/1ns
module rrte_core_tb;
    import rrte_pkg::*;
    logic               CLK = 1'b0;
    logic               ARST_N = 1'b0;
    logic               INSTR_VALID = 1'b0;
    logic [INSTR_W-1:0] INSTR = '0;
    logic [STK_W-1:0]   STACK_LEVEL = '0;
    logic               CARRY_LOAD = 1'b0;
    logic               CARRY_IN = 1'b0;
    logic [3:0]         ACC, REG_B, PTR_X, PTR_Y, acc, b, x, y, mem [1024];
    logic [1:0]         PTR_Z, z;
    logic [2:0]         PTR_D, d;
    logic [7:0]         REG_E, e;
    logic               CARRY, SKIP_PENDING, INSTR_SKIPPED, INSTR_UNKNOWN;
    logic               cf, skp, lpt, p_skp, p_unk;
    int                 error_cnt = 0, n_checks = 0, cyc = 0, i;
    logic [9:0]         fx [13] = '{OPC_B2A, OPC_A2B, OPC_Y2A, OPC_A2Y, OPC_P2E, OPC_E2P,
        OPC_A2D, OPC_D2A, OPC_Z2A, OPC_X2A, OPC_SP2A, OPC_INC, OPC_DEC};

    rrte_core rrte_core_inst (.CLK, .ARST_N, .INSTR_VALID, .INSTR, .STACK_LEVEL,
        .CARRY_LOAD, .CARRY_IN, .ACC, .REG_B, .PTR_X, .PTR_Y, .PTR_Z, .PTR_D, .REG_E,
        .CARRY, .SKIP_PENDING, .INSTR_SKIPPED, .INSTR_UNKNOWN);

    always #2 CLK = ~CLK;

    // a hang counts as a mismatch
    always @(posedge CLK) begin
        cyc++;
        if (cyc > 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    task tally_and_finish;
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task do_reset;
        ARST_N = 1'b0;
        INSTR_VALID = 1'b0;
        repeat (4) @(posedge CLK);
        #1;
        chk({ACC, REG_B, PTR_X, PTR_Y, PTR_Z, PTR_D, REG_E, CARRY, SKIP_PENDING}, '0);
        ARST_N = 1'b1;
        {acc, b, x, y, z, d, e, cf, skp, lpt} = '0;
    endtask : do_reset

    function automatic logic [9:0] rnd_ins();
        int         k;
        logic [7:0] j;
        k = $urandom_range(20, 0);
        j = 8'($urandom);
        case (k)
            13: return {PFX_LPT, j};
            14: return {PFX_LB, j[1:0]};
            15: return {PFX_LDM, j[3:0]};
            16: return {PFX_SWM, j[3:0]};
            17: return {PFX_SWMI, j[3:0]};
            18: return {PFX_SWMD, j[3:0]};
            19: return {PFX_STM, j[3:0]};
            20: return {6'h07, j[3:0]};
            default: return fx[k];
        endcase
    endfunction : rnd_ins

    // drive one cycle, advance the model, compare after the edge
    task step(input logic [9:0] ins, input logic v);
        logic [9:0] a;
        logic [5:0] g;
        INSTR = ins;
        INSTR_VALID = v;
        STACK_LEVEL = 3'($urandom);
        CARRY_LOAD = ($urandom_range(3, 0) == 0);
        CARRY_IN = 1'($urandom);
        {p_skp, p_unk} = 2'h0;
        g = ins[9:4];
        a = {z, x, y};
        if (CARRY_LOAD) cf = CARRY_IN;
        if (v && (skp || (lpt && ins[9:8] == PFX_LPT))) begin
            p_skp = 1'b1;
            skp = 1'b0;
        end else if (v) begin
            case (ins)
                OPC_B2A: acc = b;
                OPC_A2B: b = acc;
                OPC_Y2A: acc = y;
                OPC_A2Y: y = acc;
                OPC_P2E: e = {b, acc};
                OPC_E2P: {b, acc} = e;
                OPC_A2D: d = acc[2:0];
                OPC_D2A: acc = {1'b0, d};
                OPC_Z2A: acc = {2'h0, z};
                OPC_X2A: acc = x;
                OPC_SP2A: acc = {1'b0, STACK_LEVEL};
                OPC_INC: y = y + 4'h1;
                OPC_DEC: y = y - 4'h1;
                default: begin
                    if (ins[9:8] == PFX_LPT) {x, y} = ins[7:0];
                    else if (ins[9:2] == PFX_LB) z = ins[1:0];
                    else if (g inside {PFX_LDM, PFX_SWM, PFX_SWMI, PFX_SWMD, PFX_STM}) begin
                        {acc, mem[a]} = {(g == PFX_STM) ? acc : mem[a],
                                         (g == PFX_LDM) ? mem[a] : acc};
                        x = x ^ ins[3:0];
                        y = y + (g == PFX_SWMI) - (g == PFX_SWMD);
                    end else p_unk = 1'b1;
                end
            endcase
            if (ins == OPC_INC || g == PFX_SWMI) skp = (y == 4'h0);
            if (ins == OPC_DEC || g == PFX_SWMD) skp = (y == 4'hF);
        end
        if (v) lpt = (ins[9:8] == PFX_LPT);
        @(posedge CLK);
        #1;
        chk({ACC, REG_B}, {acc, b});
        chk({PTR_D, REG_E}, {d, e});
        chk({PTR_X, PTR_Y, PTR_Z}, {x, y, z});
        chk(CARRY, cf);
        chk({INSTR_SKIPPED, INSTR_UNKNOWN}, {p_skp, p_unk});
        chk(SKIP_PENDING, skp);
    endtask : step

    initial begin
        i = $urandom(9);
        do_reset();
        // fill every ram cell, the wrap skip eats the trailing transfer
        for (i = 0; i < 64; i++) begin
            step({PFX_LB, i[5:4]}, 1'b1);
            step({PFX_LPT, i[3:0], 4'h0}, 1'b1);
            repeat (16) begin
                step(OPC_Y2A, 1'b1);
                step({PFX_STM, 4'h0}, 1'b1);
                step(OPC_INC, 1'b1);
            end
            step(OPC_B2A, 1'b1);
        end
        // chained pointer loads across a gap
        step({PFX_LPT, 8'h12}, 1'b1);
        step({PFX_LPT, 8'h9A}, 1'b0);
        step({PFX_LPT, 8'h34}, 1'b1);
        step({PFX_LPT, 8'h56}, 1'b1);
        step(OPC_X2A, 1'b1);
        for (i = 0; i < 3000; i++) begin
            if (i == 1500) do_reset();
            step(rnd_ins(), $urandom_range(7, 0) != 0);
        end
        tally_and_finish();
    end
endmodule : rrte_core_tb
